// ==== design/feed_pkg.sv ====
// shared constants and carrier types for the link feed selector
package feed_pkg;
	localparam logic [15:0] FEED_CTL_ADDR   = 16'h0891; // converter_feed_control
	localparam logic [15:0] PRBS_CTL_ADDR   = 16'h080b; // pseudo_random_kind register
	localparam logic [15:0] LANE_CTL_ADDR   = 16'h0871; // lane control, sleep bit only
	localparam logic [7:0]  FEED_CTL_RESET  = 8'h00;
	localparam logic [7:0]  PRBS_CTL_RESET  = 8'h00;
	localparam logic [7:0]  LANE_CTL_RESET  = 8'h00;
	localparam int          FEED_SEL_LSB    = 4;
	localparam int          CONV_SLEEP_BIT  = 0;
	localparam int          LANE_SLEEP_BIT  = 0;
	localparam logic [7:0]  FEED_CTL_WMASK  = 8'h31;
	localparam logic [7:0]  PRBS_CTL_WMASK  = 8'h03;
	localparam logic [7:0]  LANE_CTL_WMASK  = 8'h01;
	localparam logic [13:0] DUMMY_WORD      = 14'h26ea; // 10011011101010
	localparam logic [30:0] PRBS_SEED       = 31'h7fffffff;
	localparam int          FIFO_DEPTH      = 16;

	typedef enum logic [1:0]
	{
		FEED_CONV  = 2'h0,
		FEED_UNUSED = 2'h1,
		FEED_DUMMY = 2'h2,
		FEED_PRBS  = 2'h3
	} feed_sel_t;

	typedef enum logic [1:0]
	{
		PRBS_K7A = 2'h0,
		PRBS_K7B = 2'h1,
		PRBS_K23 = 2'h2,
		PRBS_K31 = 2'h3
	} prbs_kind_t;

	// one link sample: range flag plus 14-bit word
	typedef struct packed
	{
		logic        outOfRangeFlag;
		logic [13:0] data;
	} sample_t;

	// register port access
	typedef struct packed
	{
		logic        wrEn;
		logic        rdEn;
		logic [15:0] addr;
		logic [7:0]  wdata;
	} reg_req_t;
endpackage

// ==== design/sample_fifo.sv ====
// sample fifo with valid/ready on both sides
`timescale 1ns/1ps
module sample_fifo #(
	parameter int WIDTH = 15,
	parameter int DEPTH = 16
)(
	input  wire logic             clk_sys,
	input  wire logic             reset,
	input  wire logic             clkEn,
	input  wire logic             inValid,
	output logic                  inReady,
	input  wire logic [WIDTH-1:0] inData,
	output logic                  outValid,
	input  wire logic             outReady,
	output logic      [WIDTH-1:0] outData
);
	localparam int AW = $clog2(DEPTH);
	logic [WIDTH-1:0] mem [DEPTH];
	logic [AW-1:0]    wrPtr_r, wrPtr_nxt, rdPtr_r, rdPtr_nxt;
	logic [AW:0]      count_r, count_nxt;
	logic             doWr, doRd;

	// honest flags from the occupancy count
	always_comb
	begin
		inReady   = (count_r != (AW+1)'(DEPTH));
		outValid  = (count_r != '0);
		outData   = mem[rdPtr_r];
		doWr      = clkEn && inValid && inReady;
		doRd      = clkEn && outValid && outReady;
		wrPtr_nxt = doWr ? wrPtr_r + AW'(1) : wrPtr_r;
		rdPtr_nxt = doRd ? rdPtr_r + AW'(1) : rdPtr_r;
		count_nxt = count_r + (AW+1)'(doWr) - (AW+1)'(doRd);
	end

	// storage has no reset, pointers do
	always_ff @(posedge clk_sys)
	begin
		if (doWr)
			mem[wrPtr_r] <= inData;
	end

	always_ff @(posedge clk_sys or posedge reset)
	begin
		if (reset)
		begin
			wrPtr_r <= '0;
			rdPtr_r <= '0;
			count_r <= '0;
		end
		else
		begin
			wrPtr_r <= wrPtr_nxt;
			rdPtr_r <= rdPtr_nxt;
			count_r <= count_nxt;
		end
	end
endmodule

// ==== design/link_feed_ctl.sv ====
// feed selector, prbs source and power-down controls ahead of the link framer
`timescale 1ns/1ps
// Contract
// - lane sleep bit 1 powers lane down
// - feed code 00 passes converter samples
// - feed code 10 sends fixed dummy sample
// - feed code 11 sends pseudo-random generator output
// - converter sleep bit 1 powers core down
// - kind 00/01 prbs7, 10 prbs23, 11 prbs31
module link_feed_ctl #(
	parameter int DEPTH = feed_pkg::FIFO_DEPTH
)(
	input  wire logic             clk_sys,
	input  wire logic             reset,
	input  wire logic             clkEn,
	input  wire feed_pkg::reg_req_t regReq,
	output logic      [7:0]       regRdata,
	input  wire feed_pkg::sample_t convSample,
	input  wire logic             convValid,
	output logic                  convReady,
	output feed_pkg::sample_t     linkSample,
	output logic                  linkValid,
	input  wire logic             linkReady,
	output logic                  laneSleep,
	output logic                  converterSleep
);
	logic [7:0]        feedCtl_r, feedCtl_nxt;
	logic [7:0]        prbsCtl_r, prbsCtl_nxt;
	logic [7:0]        laneCtl_r, laneCtl_nxt;
	logic [7:0]        rdata_r, rdata_nxt;
	logic [30:0]       lfsr_r, lfsr_nxt;
	logic              linkValid_r, linkValid_nxt;
	feed_pkg::sample_t linkSample_r, linkSample_nxt;
	feed_pkg::feed_sel_t  feedSel;
	feed_pkg::prbs_kind_t prbsKind;
	feed_pkg::sample_t srcSample, fifoOut;
	logic              srcValid, srcReady, fifoValid, fifoReady, fb, lfsrStep;

	assign feedSel  = feed_pkg::feed_sel_t'(feedCtl_r[feed_pkg::FEED_SEL_LSB +: 2]);
	assign prbsKind = feed_pkg::prbs_kind_t'(prbsCtl_r[1:0]);

	// register writes, masked to defined bits; reads return the stored byte
	always_comb
	begin
		feedCtl_nxt = feedCtl_r;
		prbsCtl_nxt = prbsCtl_r;
		laneCtl_nxt = laneCtl_r;
		rdata_nxt   = rdata_r;
		if (regReq.wrEn)
		begin
			if (regReq.addr == feed_pkg::FEED_CTL_ADDR)
				feedCtl_nxt = regReq.wdata & feed_pkg::FEED_CTL_WMASK;
			else if (regReq.addr == feed_pkg::PRBS_CTL_ADDR)
				prbsCtl_nxt = regReq.wdata & feed_pkg::PRBS_CTL_WMASK;
			else if (regReq.addr == feed_pkg::LANE_CTL_ADDR)
				laneCtl_nxt = regReq.wdata & feed_pkg::LANE_CTL_WMASK;
		end
		if (regReq.rdEn)
		begin
			if (regReq.addr == feed_pkg::FEED_CTL_ADDR)
				rdata_nxt = feedCtl_r;
			else if (regReq.addr == feed_pkg::PRBS_CTL_ADDR)
				rdata_nxt = prbsCtl_r;
			else if (regReq.addr == feed_pkg::LANE_CTL_ADDR)
				rdata_nxt = laneCtl_r;
			else
				rdata_nxt = 8'h00; // unmapped reads as zero
		end
	end

	// prbs feedback taps per kind; 00 and 01 both give the 7-bit one
	always_comb
	begin
		case (prbsKind)
			feed_pkg::PRBS_K23: fb = lfsr_r[22] ^ lfsr_r[17];
			feed_pkg::PRBS_K31: fb = lfsr_r[30] ^ lfsr_r[27];
			default:            fb = lfsr_r[6] ^ lfsr_r[5];
		endcase
		lfsr_nxt = lfsrStep ? {lfsr_r[29:0], fb} : lfsr_r;
	end

	// source select; unused code falls through to converter data
	always_comb
	begin
		case (feedSel)
			feed_pkg::FEED_DUMMY:
			begin
				srcSample = '{outOfRangeFlag: 1'b0, data: feed_pkg::DUMMY_WORD};
				srcValid  = 1'b1;
			end
			feed_pkg::FEED_PRBS:
			begin
				srcSample = '{outOfRangeFlag: 1'b0, data: lfsr_r[13:0]};
				srcValid  = 1'b1;
			end
			default:
			begin
				srcSample = convSample;
				srcValid  = convValid;
			end
		endcase
		convReady = (feedSel == feed_pkg::FEED_CONV || feedSel == feed_pkg::FEED_UNUSED)
			? srcReady : 1'b0;
		lfsrStep  = clkEn && srcReady && (feedSel == feed_pkg::FEED_PRBS);
	end

	sample_fifo #(
		.WIDTH ($bits(feed_pkg::sample_t)),
		.DEPTH (DEPTH)
	) u_sample_fifo (
		.clk_sys  (clk_sys),
		.reset    (reset),
		.clkEn    (clkEn),
		.inValid  (srcValid),
		.inReady  (srcReady),
		.inData   (srcSample),
		.outValid (fifoValid),
		.outReady (fifoReady),
		.outData  (fifoOut)
	);

	// registered output stage, refilled when empty or consumed
	always_comb
	begin
		fifoReady      = !linkValid_r || linkReady;
		linkValid_nxt  = linkValid_r;
		linkSample_nxt = linkSample_r;
		if (fifoReady)
		begin
			linkValid_nxt  = fifoValid;
			linkSample_nxt = fifoValid ? fifoOut : linkSample_r;
		end
	end

	always_ff @(posedge clk_sys or posedge reset)
	begin
		if (reset)
		begin
			feedCtl_r    <= feed_pkg::FEED_CTL_RESET;
			prbsCtl_r    <= feed_pkg::PRBS_CTL_RESET;
			laneCtl_r    <= feed_pkg::LANE_CTL_RESET;
			rdata_r      <= 8'h00;
			lfsr_r       <= feed_pkg::PRBS_SEED;
			linkValid_r  <= 1'b0;
			linkSample_r <= '0;
		end
		else if (clkEn)
		begin
			feedCtl_r    <= feedCtl_nxt;
			prbsCtl_r    <= prbsCtl_nxt;
			laneCtl_r    <= laneCtl_nxt;
			rdata_r      <= rdata_nxt;
			lfsr_r       <= lfsr_nxt;
			linkValid_r  <= linkValid_nxt;
			linkSample_r <= linkSample_nxt;
		end
	end

	// power-down levels come straight from the control flops
	assign laneSleep      = laneCtl_r[feed_pkg::LANE_SLEEP_BIT];
	assign converterSleep = feedCtl_r[feed_pkg::CONV_SLEEP_BIT];
	assign regRdata       = rdata_r;
	assign linkValid      = linkValid_r;
	assign linkSample     = linkSample_r;
endmodule

// ==== test/link_feed_props.sv ====
// port assertions for the feed selector
`timescale 1ns/1ps
module link_feed_props(
	input wire logic               clk_sys,
	input wire logic               reset,
	input wire logic               clkEn,
	input wire feed_pkg::reg_req_t regReq,
	input wire logic [7:0]         regRdata,
	input wire logic               convReady,
	input wire feed_pkg::sample_t  linkSample,
	input wire logic               linkValid,
	input wire logic               linkReady,
	input wire logic               laneSleep,
	input wire logic               converterSleep
);
	logic [1:0] feedSel_r;
	logic [1:0] feedSel_nxt;
	logic       wr;
	logic       rd;
	// only strobes seen with clkEn count
	assign wr = clkEn && regReq.wrEn;
	assign rd = clkEn && regReq.rdEn;
	// mirror of the feed code
	always_comb
	begin
		feedSel_nxt = feedSel_r;
		if (wr && regReq.addr == feed_pkg::FEED_CTL_ADDR)
			feedSel_nxt = regReq.wdata[5:4];
	end
	always_ff @(posedge clk_sys or posedge reset)
		if (reset)
			feedSel_r <= 2'h0;
		else
			feedSel_r <= feedSel_nxt;
	default clocking cb @(posedge clk_sys); endclocking
	default disable iff (reset);
	chk_lane_sleep_wr:
	assert property (wr && regReq.addr == feed_pkg::LANE_CTL_ADDR
		|=> laneSleep == $past(regReq.wdata[0])) else $error("lane sleep");
	chk_lane_sleep_stands:
	assert property ($changed(laneSleep) |-> $past(wr && regReq.addr == feed_pkg::LANE_CTL_ADDR))
		else $error("lane sleep moved");
	chk_conv_sleep_wr:
	assert property (wr && regReq.addr == feed_pkg::FEED_CTL_ADDR
		|=> converterSleep == $past(regReq.wdata[0])) else $error("core sleep");
	chk_feed_blocks_conv:
	assert property (feedSel_r[1] |-> !convReady) else $error("converter taken");
	chk_feed_read:
	assert property (rd && regReq.addr == feed_pkg::FEED_CTL_ADDR
		|=> regRdata == {2'h0, $past(feedSel_r), 3'h0, $past(converterSleep)})
		else $error("feed read");
	chk_kind_read:
	assert property (rd && regReq.addr == feed_pkg::PRBS_CTL_ADDR |=> regRdata[7:2] == 6'h00)
		else $error("kind read");
	chk_link_hold:
	assert property (linkValid && !linkReady |=> linkValid && $stable(linkSample))
		else $error("link word dropped");
endmodule

// ==== test/link_sink_model.sv ====
// link receiver stand-in: ready, random stalls or full stall
`timescale 1ns/1ps
module link_sink_model(
	input  wire logic       clk_sys,
	input  wire logic [1:0] stallMode,
	output logic            linkReady
);
	int seed = 32'hb9ea;
	// ready moves just after an edge, as a real sink would
	initial linkReady = 1'b1;
	always @(posedge clk_sys)
		linkReady <= #1 stallMode == 2'h0 || (stallMode == 2'h1 && $random(seed) & 1);
endmodule

// ==== test/serializer_source_and_powerdown_tb_top.sv ====
// bench for the feed selector
`timescale 1ns/1ps
`define CHK(a, e) begin checked++; if ((a) !== (e)) begin errorCnt++; \
	$display("[ERR] %0t got %h exp %h", $time, a, e); end end
module serializer_source_and_powerdown_tb_top;
	localparam logic [15:0] FA = feed_pkg::FEED_CTL_ADDR;
	localparam logic [15:0] PA = feed_pkg::PRBS_CTL_ADDR;
	localparam logic [15:0] LA = feed_pkg::LANE_CTL_ADDR;
	logic clk_sys = 0, reset = 1, clkEn = 1, convValid = 0, same;
	logic convReady, linkValid, linkReady, laneSleep, converterSleep;
	logic [7:0] regRdata;
	logic [1:0] stallMode = 0;
	feed_pkg::reg_req_t regReq = '0;
	feed_pkg::sample_t convSample = '0, linkSample, e, expQ[$], got[$];
	int seed = 32'hb9ea, errorCnt = 0, checked = 0;
	bit grab = 0;
	always #50 clk_sys = ~clk_sys;
	link_feed_ctl u_link_feed_ctl(.clk_sys(clk_sys), .reset(reset), .clkEn(clkEn),
		.regReq(regReq), .regRdata(regRdata), .convSample(convSample), .convValid(convValid),
		.convReady(convReady), .linkSample(linkSample), .linkValid(linkValid),
		.linkReady(linkReady), .laneSleep(laneSleep), .converterSleep(converterSleep));
	link_sink_model u_link_sink_model(.clk_sys(clk_sys), .stallMode(stallMode),
		.linkReady(linkReady));
	// accepted link words meet the oldest note, or are kept for the generator checks
	always @(negedge clk_sys)
		if (linkValid && linkReady && clkEn)
			if (grab)
				got.push_back(linkSample);
			else if (expQ.size() > 0)
			begin
				e = expQ.pop_front();
				`CHK(linkSample, e)
			end
			else
				`CHK(1'b0, 1'b1)
	task automatic wr(input logic [15:0] a, input logic [7:0] d);
		@(posedge clk_sys) #1;
		regReq = '{1'b1, 1'b0, a, d};
		@(posedge clk_sys) #1;
		regReq.wrEn = 0;
	endtask
	task automatic rd(input logic [15:0] a, input logic [7:0] x);
		@(posedge clk_sys) #1;
		regReq = '{1'b0, 1'b1, a, 8'h00};
		@(posedge clk_sys) #1;
		regReq.rdEn = 0;
		@(posedge clk_sys) #1;
		`CHK(regRdata, x)
	endtask
	// random samples, clkEn dropped now and then; cap stops a refused source
	task automatic send(input int n, input int cap);
		while (n > 0 && cap > 0)
		begin
			@(posedge clk_sys) #1;
			convValid = 1;
			convSample = 15'($random(seed));
			clkEn = ($random(seed) & 3) != 0;
			@(negedge clk_sys);
			if (convReady && clkEn)
			begin
				expQ.push_back(convSample);
				n--;
			end
			cap--;
		end
		@(posedge clk_sys) #1;
		convValid = 0;
		clkEn = 1;
	endtask
	task automatic drain(input string t);
		for (int i = 0; i < 4000 && expQ.size() > 0; i++)
			@(posedge clk_sys);
		`CHK(expQ.size() == 0, 1'b1)
		$display("end %s", t);
	endtask
	task automatic summarize();
		$display("checks %0d errors %0d", checked, errorCnt);
		if (errorCnt == 0 && checked > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask
	initial
	begin
		#2000000;
		errorCnt++;
		summarize();
	end
	initial
	begin
		repeat (2) @(posedge clk_sys);
		#1 reset = 0;
		rd(FA, 8'h00);
		rd(PA, 8'h00);
		rd(16'h0000, 8'h00);
		wr(LA, 8'hff);
		rd(LA, 8'h01);
		`CHK(laneSleep, 1'b1)
		wr(LA, 8'h00);
		rd(LA, 8'h00);
		`CHK(laneSleep, 1'b0)
		wr(FA, 8'hc1);
		rd(FA, 8'h01);
		`CHK(converterSleep, 1'b1)
		wr(FA, 8'h00);
		rd(FA, 8'h00);
		`CHK(converterSleep, 1'b0)
		wr(PA, 8'hff);
		rd(PA, 8'h03);
		rd(16'h0000, 8'h00); // unmapped reads as zero after a nonzero read
		wr(16'h0892, 8'hff);
		rd(FA, 8'h00);
		$display("end regs");
		// converter feed under codes 00 and 01, sink stalling at random
		stallMode = 1;
		for (int c = 0; c < 2; c++)
		begin
			wr(FA, 8'(c << 4));
			send(40, 400);
			drain("conv");
		end
		// sink frozen: buffer fills and refuses, then empties
		stallMode = 2;
		send(40, 40);
		@(negedge clk_sys) `CHK(convReady, 1'b0)
		stallMode = 0;
		drain("fill");
		wr(FA, 8'h20);
		repeat (10) expQ.push_back({1'b0, feed_pkg::DUMMY_WORD});
		drain("dummy");
		// generator: short kinds repeat every 127 words, long ones do not
		grab = 1;
		wr(FA, 8'h30);
		for (int k = 0; k < 4; k++)
		begin
			wr(PA, 8'(k));
			got.delete();
			for (int i = 0; i < 400 && got.size() < 180; i++)
				@(posedge clk_sys);
			same = 1;
			for (int i = 40; i < 48; i++)
				same &= got[i] === got[i + 127];
			`CHK(same, k < 2)
			`CHK(got[40].outOfRangeFlag, 1'b0)
		end
		$display("end prbs");
		summarize();
	end
endmodule
bind link_feed_ctl link_feed_props u_link_feed_props(.*);
